//--- rtl/imvx_core.sv
// Decode and execution of the short and long indexed-to-direct moves.
`timescale 1ns/100ps
`include "imvx_params.svh"
module imvx_core (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  q_phase,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [13:0] frame_pointer_reg,
  input  wire logic [7:0]  mem_rdata,
  output logic [13:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  output logic             ext_nop,
  output logic             busy
);
  // ****************************************
  // State
  // ****************************************
  // The whole state lives in one struct so the next-value logic is one process.
  typedef struct packed {
    imvx_pkg::imvx_state_t st;
    logic [13:0] src;
    logic [13:0] dst;
    logic [13:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic        nop;
    logic        busy;
  } imvx_core_t;

  imvx_core_t state_reg;
  imvx_core_t state_next;
  logic [7:0] src_byte;
  logic       capture;

  function automatic logic [13:0] imvx_index(input logic [13:0] fp, input logic [6:0] off);
    imvx_index = fp + {7'h00, off};
  endfunction

  wire is_q1 = (q_phase == 2'(imvx_pkg::IMVX_Q1));
  wire is_q2 = (q_phase == 2'(imvx_pkg::IMVX_Q2));
  wire is_q4 = (q_phase == 2'(imvx_pkg::IMVX_Q4));
  wire word_in = instr_valid && is_q1;

  // The source byte is taken in Q2 of the last cycle, one clock after the memory has answered a short read and three clocks after a long one.
  // Taking it on the Q4 edge would race the write that uses it on that same edge.
  assign capture = is_q2 && (state_reg.st == imvx_pkg::IMVX_SHORT_C2 || state_reg.st == imvx_pkg::IMVX_LONG_C3);

  imvx_src_map u_src_map (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .src_addr (state_reg.src),
    .raw_data (mem_rdata),
    .capture  (capture),
    .byte_reg (src_byte)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.rd = 1'b0;
    state_next.wr = 1'b0;
    state_next.nop = 1'b0;
    unique case (state_reg.st)
      imvx_pkg::IMVX_IDLE: begin
        if (word_in && instr_word[15:7] == `IMVX_SHORT_W1_TOP) begin
          state_next.src = imvx_index(frame_pointer_reg, instr_word[6:0]) & `IMVX_SHORT_ADDR_MAX;
          state_next.st = imvx_pkg::IMVX_SHORT_C1;
        end else if (word_in && instr_word == `IMVX_LONG_W1) begin
          state_next.st = imvx_pkg::IMVX_LONG_C1;
        end else if (word_in && instr_word[15:12] == `IMVX_EXT_TOP) begin
          state_next.nop = 1'b1;
        end
      end
      imvx_pkg::IMVX_SHORT_C1: begin
        if (is_q2 && !state_reg.busy) begin
          state_next.busy = 1'b1;
        end
        if (is_q4 && state_reg.busy) begin
          state_next.addr = state_reg.src;
          state_next.rd = 1'b1;
        end
        if (word_in && state_reg.busy) begin
          state_next.dst = {2'b00, instr_word[11:0]};
          state_next.st = imvx_pkg::IMVX_SHORT_C2;
        end
      end
      imvx_pkg::IMVX_SHORT_C2: begin
        state_next.addr = `IMVX_NO_ADDR;
        if (is_q4) begin
          state_next.addr = state_reg.dst;
          state_next.wr = 1'b1;
          state_next.wdata = src_byte;
          state_next.busy = 1'b0;
          state_next.st = imvx_pkg::IMVX_IDLE;
        end
      end
      imvx_pkg::IMVX_LONG_C1: begin
        state_next.busy = 1'b1;
        if (word_in) begin
          state_next.src = imvx_index(frame_pointer_reg, instr_word[8:2]);
          state_next.dst[13:12] = instr_word[1:0];
          state_next.st = imvx_pkg::IMVX_LONG_C2;
        end
      end
      imvx_pkg::IMVX_LONG_C2: begin
        if (is_q2) begin
          state_next.addr = state_reg.src;
          state_next.rd = 1'b1;
        end
        if (word_in) begin
          state_next.dst[11:0] = instr_word[11:0];
          state_next.st = imvx_pkg::IMVX_LONG_C3;
        end
      end
      imvx_pkg::IMVX_LONG_C3: begin
        state_next.addr = `IMVX_NO_ADDR;
        if (is_q4) begin
          state_next.addr = state_reg.dst;
          state_next.wr = 1'b1;
          state_next.wdata = src_byte;
          state_next.busy = 1'b0;
          state_next.st = imvx_pkg::IMVX_IDLE;
        end
      end
      default: begin
        state_next.st = imvx_pkg::IMVX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= '{st: imvx_pkg::IMVX_IDLE, src: `IMVX_FP_RESET, dst: `IMVX_NO_ADDR,
                     addr: `IMVX_NO_ADDR, rd: 1'b0, wr: 1'b0, wdata: 8'h00, nop: 1'b0, busy: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Reads are issued in Q2 or Q4; the memory answers one edge later and the data stands until it is captured.
  assign mem_addr  = state_reg.addr;
  assign mem_rd    = state_reg.rd;
  assign mem_wr    = state_reg.wr;
  assign mem_wdata = state_reg.wdata;
  assign ext_nop   = state_reg.nop;
  assign busy      = state_reg.busy;

  // ****************************************
  // Checks
  // ****************************************
  short_range_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mem_wr && state_reg.st == imvx_pkg::IMVX_IDLE && $past(state_reg.st) == imvx_pkg::IMVX_SHORT_C2)
    |-> mem_addr <= `IMVX_SHORT_ADDR_MAX)
    else $error("short move wrote above 4 Kbyte");
  short_no_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.st == imvx_pkg::IMVX_SHORT_C2) |-> !mem_rd)
    else $error("dummy read in short second cycle");
  short_q4_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(mem_wr) |-> $past(q_phase) == 2'(imvx_pkg::IMVX_Q4))
    else $error("write outside Q4");
  write_data_a: assert property (@(posedge clock) disable iff (sys_rst)
    mem_wr |-> mem_wdata == $past(src_byte))
    else $error("write data not source byte");
  ext_nop_a: assert property (@(posedge clock) disable iff (sys_rst)
    ext_nop |-> !busy && !mem_wr && !mem_rd)
    else $error("stray word not a no-operation");
  short_src_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.st == imvx_pkg::IMVX_IDLE && word_in && instr_word[15:7] == `IMVX_SHORT_W1_TOP)
    |=> state_reg.src == ((($past(frame_pointer_reg) + {7'h00, $past(instr_word[6:0])}) & `IMVX_SHORT_ADDR_MAX)))
    else $error("short source address wrong");
  long_src_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.st == imvx_pkg::IMVX_LONG_C1 && word_in)
    |=> state_reg.src == 14'($past(frame_pointer_reg) + {7'h00, $past(instr_word[8:2])}))
    else $error("long source address wrong");
  long_dst_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.st == imvx_pkg::IMVX_LONG_C2 && word_in)
    |=> state_reg.dst[11:0] == $past(instr_word[11:0]))
    else $error("long destination low bits wrong");
  short_done_c: cover property (@(posedge clock) $fell(busy) && $past(state_reg.st) == imvx_pkg::IMVX_SHORT_C2);
  long_done_c: cover property (@(posedge clock) $fell(busy) && $past(state_reg.st) == imvx_pkg::IMVX_LONG_C3);
  ext_nop_c: cover property (@(posedge clock) ext_nop);
endmodule

//--- rtl/imvx_src_map.sv
// Classifies a source address and forms the byte actually delivered.
`timescale 1ns/100ps
`include "imvx_params.svh"
module imvx_src_map (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [13:0] src_addr,
  input  wire logic [7:0]  raw_data,
  input  wire logic        capture,
  output logic [7:0]       byte_reg
);
  // ****************************************
  // Indirect register detection
  // ****************************************
  function automatic logic imvx_is_indirect(input logic [13:0] a);
    imvx_is_indirect = (a == `IMVX_INDF_LO) || (a == `IMVX_INDF_HI) ||
                       (a == `IMVX_INDF_LO - `IMVX_INDF_STEP);
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      byte_reg <= 8'h00;
    end else if (capture) begin
      byte_reg <= imvx_is_indirect(src_addr) ? `IMVX_INDF_READ_VAL : raw_data;
    end
  end
endmodule

//--- shared/imvx_params.svh
// Constants for the indexed-to-direct move executor.
`ifndef IMVX_PARAMS_SVH
`define IMVX_PARAMS_SVH
`define IMVX_SHORT_W1_TOP    9'h1D6
`define IMVX_LONG_W1         16'h0062
`define IMVX_EXT_TOP         4'hF
`define IMVX_OFF_W           7
`define IMVX_SHORT_ADDR_W    12
`define IMVX_LONG_ADDR_W     14
`define IMVX_SHORT_ADDR_MAX  14'h0FFF
`define IMVX_INDF_LO         14'h3FE7
`define IMVX_INDF_HI         14'h3FEF
`define IMVX_INDF_STEP       14'h0008
`define IMVX_INDF_READ_VAL   8'h00
`define IMVX_FP_RESET        14'h0000
`define IMVX_NO_ADDR         14'h0000
`endif

//--- shared/imvx_pkg.sv
// Types shared by the indexed-to-direct move executor.
package imvx_pkg;
  typedef enum logic [1:0] {
    IMVX_Q1,
    IMVX_Q2,
    IMVX_Q3,
    IMVX_Q4
  } imvx_q_t;
  typedef enum logic [2:0] {
    IMVX_IDLE,
    IMVX_SHORT_C1,
    IMVX_SHORT_C2,
    IMVX_LONG_C1,
    IMVX_LONG_C2,
    IMVX_LONG_C3
  } imvx_state_t;
endpackage

//--- tb/imvx_mem_model.sv
// Behavioural data memory on the far side of the move executor.
`timescale 1ns/100ps
module imvx_mem_model (
  input  wire logic        clock,
  input  wire logic [13:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [16384];
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = 8'(i * 7 + (i >> 8)) | 8'h01;
    end
    mem_rdata = 8'h5A;
  end
  // Read data turns over once the move writes, so a stale byte is never taken for an answer.
  always @(posedge clock) begin
    if (mem_rd === 1'b1) begin
      mem_rdata <= mem[mem_addr];
    end else if (mem_wr === 1'b1) begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

//--- tb/indexed_to_direct_move_exec_bench.sv
// Self-checking bench for the indexed-to-direct move executor.
`timescale 1ns/100ps
`include "imvx_params.svh"
module indexed_to_direct_move_exec_bench;
  typedef struct packed {logic [13:0] addr; logic [7:0] data;} imvx_exp_t;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [1:0]  q_phase = 2'h0;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [13:0] frame_pointer_reg = 14'h0000;
  logic [7:0]  mem_rdata;
  logic [13:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic        ext_nop;
  logic        busy;
  logic [7:0]  shadow [16384];
  imvx_exp_t   exp_q [$];
  imvx_exp_t   e;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_rd = 0;
  int          exp_rd = 0;
  int          n_nop = 0;
  int          cyc = 0;
  always #2 clock = ~clock;
  imvx_core dut_u (.clock(clock), .sys_rst(sys_rst), .q_phase(q_phase), .instr_valid(instr_valid),
    .instr_word(instr_word), .frame_pointer_reg(frame_pointer_reg), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .ext_nop(ext_nop), .busy(busy));
  imvx_mem_model mem_u (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One instruction cycle: the word is offered only in Q1.
  task automatic phase_cycle(input logic v, input logic [15:0] w);
    for (int q = 0; q < 4; q++) begin
      @(posedge clock);
      #1;
      q_phase = 2'(q);
      instr_valid = v && (q == 0);
      instr_word = w;
    end
  endtask
  task automatic do_move(input logic lng, input logic [13:0] fp, input logic [6:0] off, input logic [13:0] dst);
    logic [13:0] src;
    logic [7:0]  val;
    frame_pointer_reg = fp;
    src = lng ? 14'(fp + off) : 14'(fp + off) & `IMVX_SHORT_ADDR_MAX;
    val = shadow[src];
    if (lng && (src == 14'h3FDF || src == 14'h3FE7 || src == 14'h3FEF)) val = 8'h00;
    shadow[dst] = val;
    exp_q.push_back(imvx_exp_t'{dst, val});
    exp_rd++;
    if (lng) begin
      phase_cycle(1'b1, `IMVX_LONG_W1);
      phase_cycle(1'b1, {4'hF, 3'($urandom), off, dst[13:12]});
      phase_cycle(1'b1, {4'hF, dst[11:0]});
    end else begin
      phase_cycle(1'b1, {`IMVX_SHORT_W1_TOP, off});
      phase_cycle(1'b1, {4'hF, dst[11:0]});
    end
  endtask
  always @(posedge clock) begin
    cyc++;
    if (mem_rd === 1'b1) begin
      n_rd++;
      check("busy at read", 16'h0001, 16'(busy));
    end
    if (ext_nop === 1'b1) n_nop++;
    if (mem_wr === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("stray write", 16'h0000, 16'h0001);
      end else begin
        e = exp_q.pop_front();
        check("busy at write", 16'h0000, 16'(busy));
        check("write addr", 16'(e.addr), 16'(mem_addr));
        check("write data", 16'(e.data), 16'(mem_wdata));
      end
    end
    if (cyc == 4000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h4B194F4F));
    for (int i = 0; i < 16384; i++) shadow[i] = 8'(i * 7 + (i >> 8)) | 8'h01;
    repeat (5) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 12; i++) do_move(1'b0, 14'($urandom), 7'($urandom), 14'($urandom) & 14'h0FFF);
    do_move(1'b0, 14'h0FFF, 7'h7F, 14'h0FFF);
    repeat (2) phase_cycle(1'b0, 16'h0000);
    check("short reads", 16'(exp_rd), 16'(n_rd));
    $display("short move test done");
    // Destinations stay below the special-function top page so no stack or counter byte is hit.
    for (int i = 0; i < 12; i++) do_move(1'b1, 14'($urandom), 7'($urandom), 14'($urandom % 16128));
    do_move(1'b1, 14'h3FFF, 7'h01, 14'h3EFF);
    for (int k = 0; k < 3; k++) do_move(1'b1, 14'h3F80, 7'h5F + 7'(k * 8), 14'h0123 + 14'(k));
    repeat (2) phase_cycle(1'b0, 16'h0000);
    check("all reads", 16'(exp_rd), 16'(n_rd));
    $display("long move test done");
    phase_cycle(1'b1, 16'hF123);
    phase_cycle(1'b1, 16'hF000 | 16'($urandom % 4096));
    repeat (2) phase_cycle(1'b0, 16'h0000);
    check("ext nop count", 16'h0002, 16'(n_nop));
    check("writes pending", 16'h0000, 16'(exp_q.size()));
    $display("stray word test done");
    summarize();
  end
endmodule
